// ### eep_pkg.sv
package eep_pkg;
    // device type code expected in the top nibble of the slave address
    localparam logic [3:0] DEV_TYPE      = 4'ha;
    // array geometry: 512 pages of 64 bytes
    localparam int         MEM_AW        = 15;
    localparam int         PAGE_AW       = 9;
    localparam int         OFF_AW        = 6;
    localparam int         PAGE_BYTES    = 64;
    localparam logic [7:0] ERASED        = 8'hff;
    // bit count of a byte on the wire, acknowledge slot excluded
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    // synchroniser reset: scl and sda idle high, straps and wp low
    localparam logic [5:0] SYNC_RST      = 6'h03;
    // internal write cycle time and its length in clk cycles
    localparam int         T_WR_MS       = 5;
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         WR_CYC        = T_WR_MS * 1000000 / CLK_PERIOD_NS;
    localparam int         WR_CW         = 17;

    typedef enum logic [2:0] {
        S_IDLE, S_DEV, S_AHI, S_ALO, S_DAT, S_TX, S_IGN
    } eep_state_t;
endpackage

// ### eep_pin_if.sv
`timescale 1ns/1ps
// synchronised pin levels and bus events
interface eep_pin_if;
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] sel;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    modport src (output scl, sda, wp, sel, scl_rise, scl_fall, start_det,
                 stop_det);
    modport dst (input scl, sda, wp, sel, scl_rise, scl_fall, start_det,
                 stop_det);
endinterface

// ### eep_sync.sv
`timescale 1ns/1ps
module eep_sync (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_pin,
    input  wire logic       sda_pin,
    input  wire logic       wp_pin,
    input  wire logic [2:0] sel_pin,
    eep_pin_if.src          pins
);
    import eep_pkg::*;

    logic [5:0] raw;
    logic [5:0] s1;
    logic [5:0] s2;
    logic       scl_d;
    logic       sda_d;

    assign raw = {sel_pin, wp_pin, sda_pin, scl_pin};

    // two flops per pin before anything looks at it
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1[i] <= SYNC_RST[i];
                    s2[i] <= SYNC_RST[i];
                end else begin
                    s1[i] <= raw[i];
                    s2[i] <= s1[i];
                end
            end
        end
    endgenerate

    // previous synced levels for edge finding
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= s2[0];
            sda_d <= s2[1];
        end
    end

    // sda moving while scl stays high marks start or stop
    assign pins.scl       = s2[0];
    assign pins.sda       = s2[1];
    assign pins.wp        = s2[2];
    assign pins.sel       = s2[5:3];
    assign pins.scl_rise  = s2[0] & ~scl_d;
    assign pins.scl_fall  = ~s2[0] & scl_d;
    assign pins.start_det = s2[0] & scl_d & sda_d & ~s2[1];
    assign pins.stop_det  = s2[0] & scl_d & ~sda_d & s2[1];
endmodule

// ### eep_pagebuf.sv
`timescale 1ns/1ps
module eep_pagebuf (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clr,
    input  wire logic                       wr_en,
    input  wire logic [eep_pkg::OFF_AW-1:0] wr_idx,
    input  wire logic [7:0]                 wr_data,
    input  wire logic [eep_pkg::OFF_AW-1:0] rd_idx,
    output logic      [7:0]                 rd_data,
    output logic      [eep_pkg::PAGE_BYTES-1:0] loaded
);
    import eep_pkg::*;

    logic [7:0] mem [PAGE_BYTES];

    // one byte slot and one loaded flag per page position
    genvar i;
    generate
        for (i = 0; i < PAGE_BYTES; i++) begin : g_slot
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem[i]    <= ERASED;
                    loaded[i] <= 1'b0;
                end else if (wr_en && wr_idx == OFF_AW'(i)) begin
                    mem[i]    <= wr_data;
                    loaded[i] <= 1'b1;
                end else if (clr) begin
                    loaded[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign rd_data = mem[rd_idx];
endmodule

// ### eep_slave.sv
`timescale 1ns/1ps
module eep_slave #(
    parameter int WR_CYCLES = eep_pkg::WR_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       scl,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic                       wp,
    input  wire logic                       addr_select_bit0,
    input  wire logic                       addr_select_bit1,
    input  wire logic                       addr_select_bit2,
    output logic      [eep_pkg::MEM_AW-1:0] mem_raddr,
    input  wire logic [7:0]                 mem_rdata,
    output logic                            mem_we,
    output logic      [eep_pkg::MEM_AW-1:0] mem_waddr,
    output logic      [7:0]                 mem_wdata,
    output logic                            busy
);
    import eep_pkg::*;

    eep_pin_if p ();

    eep_state_t              st;
    logic [7:0]              shreg;
    logic [7:0]              tx;
    logic [7:0]              hi;
    logic [3:0]              cnt;
    logic                    ackph;
    logic                    mack_ok;
    logic                    wp_lat;
    logic                    have_data;
    logic [MEM_AW-1:0]       addr;
    logic [PAGE_AW-1:0]      page;
    logic [WR_CW-1:0]        wr_cnt;
    logic [PAGE_BYTES-1:0]   loaded;
    logic [7:0]              buf_rd;
    logic                    rx_mode;
    logic                    byte_done;
    logic                    ack_end;
    logic                    dev_hit;
    logic                    tx_load;
    logic                    buf_we;
    logic                    addr_load;
    logic                    commit;

    eep_sync u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .scl_pin (scl),
        .sda_pin (sda_in),
        .wp_pin  (wp),
        .sel_pin ({addr_select_bit2, addr_select_bit1, addr_select_bit0}),
        .pins    (p)
    );

    eep_pagebuf u_buf (
        .clk     (clk),
        .rst_n   (rst_n),
        .clr     (p.start_det && !busy),
        .wr_en   (buf_we),
        .wr_idx  (addr[OFF_AW-1:0]),
        .wr_data (shreg),
        .rd_idx  (wr_cnt[OFF_AW-1:0]),
        .rd_data (buf_rd),
        .loaded  (loaded)
    );

    // open drain: only ever pulls low
    assign sda_out   = 1'b0;
    assign mem_raddr = addr;

    // byte and acknowledge event decode
    assign rx_mode   = st == S_DEV || st == S_AHI || st == S_ALO ||
                       st == S_DAT;
    assign byte_done = p.scl_fall && !ackph && cnt == BYTE_BITS && rx_mode;
    assign ack_end   = p.scl_fall && ackph;
    // pulled-down select pins arrive as zero here
    assign dev_hit   = shreg[7:4] == DEV_TYPE &&
                       shreg[3:1] == p.sel &&
                       !busy;
    assign tx_load   = ack_end && st == S_TX && mack_ok;
    assign buf_we    = byte_done && st == S_DAT && !wp_lat;
    assign addr_load = byte_done && st == S_ALO;
    assign commit    = p.stop_det && have_data && st == S_DAT;

    // protocol sequencer, shifter and sda drive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st      <= S_IDLE;
            shreg   <= 8'h00;
            tx      <= 8'h00;
            hi      <= 8'h00;
            cnt     <= 4'h0;
            ackph   <= 1'b0;
            mack_ok <= 1'b0;
            wp_lat  <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (p.start_det) begin
            st     <= S_DEV;
            cnt    <= 4'h0;
            ackph  <= 1'b0;
            sda_oe <= 1'b0;
        end else if (p.stop_det) begin
            st     <= S_IDLE;
            cnt    <= 4'h0;
            ackph  <= 1'b0;
            sda_oe <= 1'b0;
        end else if (p.scl_rise) begin
            if (!ackph && rx_mode && cnt != BYTE_BITS) begin
                shreg <= {shreg[6:0], p.sda};
                cnt   <= cnt + 4'h1;
            end
            if (ackph && st == S_TX) begin
                mack_ok <= !p.sda;
            end
        end else if (byte_done) begin
            ackph <= 1'b1;
            case (st)
                S_DEV: begin
                    if (dev_hit) begin
                        sda_oe  <= 1'b1;
                        mack_ok <= shreg[0];
                        st      <= shreg[0] ? S_TX : S_AHI;
                    end else begin
                        st <= S_IGN;
                    end
                end
                S_AHI: begin
                    hi     <= shreg;
                    sda_oe <= 1'b1;
                    st     <= S_ALO;
                end
                S_ALO: begin
                    sda_oe <= 1'b1;
                    st     <= S_DAT;
                end
                S_DAT: begin
                    if (!wp_lat) begin
                        sda_oe <= 1'b1;
                    end else begin
                        st <= S_IGN;
                    end
                end
                default: st <= S_IGN;
            endcase
        end else if (ack_end) begin
            ackph  <= 1'b0;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
            if (st == S_DAT && !have_data) begin
                wp_lat <= p.wp;
            end
            if (tx_load) begin
                tx     <= mem_rdata;
                sda_oe <= !mem_rdata[7];
                cnt    <= 4'h1;
            end else if (st == S_TX) begin
                st <= S_IGN;
            end
        end else if (p.scl_fall && st == S_TX) begin
            if (cnt == BYTE_BITS) begin
                sda_oe  <= 1'b0;
                ackph   <= 1'b1;
                mack_ok <= 1'b0;
            end else begin
                sda_oe <= !tx[6];
                tx     <= {tx[6:0], 1'b0};
                cnt    <= cnt + 4'h1;
            end
        end
    end

    // data loaded since the last start or stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            have_data <= 1'b0;
        end else if (buf_we) begin
            have_data <= 1'b1;
        end else if (p.start_det || p.stop_det) begin
            have_data <= 1'b0;
        end
    end

    // address counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr <= '0;
        end else if (addr_load) begin
            addr <= {hi[MEM_AW-9:0], shreg};
        end else if (buf_we) begin
            addr[OFF_AW-1:0] <= addr[OFF_AW-1:0] + 1'b1;
        end else if (tx_load) begin
            addr <= addr + 1'b1;
        end
    end

    // internal write cycle: sweep the page, then hold busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            wr_cnt    <= '0;
            page      <= '0;
            mem_we    <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= 8'h00;
        end else if (commit && !busy) begin
            busy   <= 1'b1;
            wr_cnt <= '0;
            page   <= addr[MEM_AW-1:OFF_AW];
        end else if (busy) begin
            mem_we    <= wr_cnt < WR_CW'(PAGE_BYTES) &&
                         loaded[wr_cnt[OFF_AW-1:0]];
            mem_waddr <= {page, wr_cnt[OFF_AW-1:0]};
            mem_wdata <= buf_rd;
            wr_cnt    <= wr_cnt + 1'b1;
            if (wr_cnt == WR_CW'(WR_CYCLES - 1)) begin
                busy <= 1'b0;
            end
        end else begin
            mem_we <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_dev_byte;
        byte_done && st == S_DEV;
    endsequence

    sequence s_ack_hold;
        sda_oe [*3];
    endsequence

    dev_type_a: assert property (
        s_dev_byte ##0 shreg[7:4] != DEV_TYPE |=> !sda_oe && st == S_IGN)
        else $error("wrong type code acked");
    sel_match_a: assert property (
        s_dev_byte ##0 shreg[3:1] != p.sel |=> !sda_oe)
        else $error("wrong select code acked");
    busy_nack_a: assert property (
        s_dev_byte ##0 busy |=> !sda_oe)
        else $error("address acked while busy");
    dev_ack_a: assert property (
        s_dev_byte ##0 dev_hit |=> s_ack_hold)
        else $error("matching address not acked");
    rw_dir_a: assert property (
        s_dev_byte ##0 dev_hit |=> st == (shreg[0] ? S_TX : S_AHI))
        else $error("direction bit misread");
    wp_reject_a: assert property (
        byte_done && st == S_DAT && wp_lat |=> !sda_oe ##0 !have_data)
        else $error("protected data byte acked");
    page_wrap_a: assert property (
        buf_we |=> addr[OFF_AW-1:0] == $past(addr[OFF_AW-1:0]) + 6'h01 &&
        addr[MEM_AW-1:OFF_AW] == $past(addr[MEM_AW-1:OFF_AW]))
        else $error("page offset did not wrap in page");
    rd_incr_a: assert property (
        tx_load |=> addr == $past(addr) + 15'h0001)
        else $error("read counter did not advance");
    rd_release_a: assert property (
        p.scl_fall && st == S_TX && !ackph && cnt == BYTE_BITS
        |=> !sda_oe && ackph)
        else $error("sda not released in ninth clock");
    no_commit_a: assert property (
        p.stop_det && !have_data && !busy |=> !busy)
        else $error("write started without data");
    commit_a: assert property (
        commit && !busy |=> busy)
        else $error("stop after data did not start write");
endmodule

// ### eep_master.sv
`timescale 1ns/1ps
// bus master model: drives scl, pulls sda low, samples the wire level
module eep_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_lo
);
    // idle bus: scl stands high, sda released
    initial begin
        scl = 1'b1;
        sda_lo = 1'b0;
    end

    // one bit: data moves mid-low, sampled just before scl falls
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge clk);
        sda_lo <= ~b;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        r = sda;
        scl <= 1'b0;
    endtask

    // start or repeated start; waits out the slave's release first
    task automatic start();
        sda_lo <= 1'b0;
        repeat (4) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_lo <= 1'b1;
        repeat (4) @(posedge clk);
        scl <= 1'b0;
    endtask

    // stop leaves scl high and sda released
    task automatic stop();
        repeat (2) @(posedge clk);
        sda_lo <= 1'b1;
        repeat (2) @(posedge clk);
        scl <= 1'b1;
        repeat (4) @(posedge clk);
        sda_lo <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // eight bits in, then our ack or no-ack
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
    import eep_pkg::*;
    localparam int         WRC = 200;
    localparam logic [2:0] SEL = 3'h5;
    logic              clk, rst_n, scl, sda, sda_lo, sda_out, sda_oe;
    logic              wp, mem_we, busy;
    logic [2:0]        sel;
    logic [MEM_AW-1:0] mem_raddr, mem_waddr;
    logic [7:0]        mem_rdata, mem_wdata;
    logic [7:0]        mem [0:32767];
    int                fails, samples_checked;

    eep_master bm (.clk(clk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
    eep_slave #(.WR_CYCLES(WRC)) DUT (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp),
        .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
        .addr_select_bit2(sel[2]), .mem_raddr(mem_raddr),
        .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_waddr(mem_waddr),
        .mem_wdata(mem_wdata), .busy(busy));

    // open-drain wire with pull-up
    assign sda = (sda_lo | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    // array model, delivered erased
    assign mem_rdata = mem[mem_raddr];
    always @(posedge clk) if (mem_we) mem[mem_waddr] <= mem_wdata;

    // free-running 40 ns system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // start, write-direction device byte and address word
    task automatic hdr(input logic [15:0] a);
        logic k;
        bm.start();
        bm.wr_byte({DEV_TYPE, SEL, 1'b0}, k);
        check(8'(k), 8'h1);
        bm.wr_byte(a[15:8], k);
        check(8'(k), 8'h1);
        bm.wr_byte(a[7:0], k);
        check(8'(k), 8'h1);
    endtask

    // (repeated) start, read two bytes, no-ack, stop
    task automatic rd_chk(input logic [7:0] e0, input logic [7:0] e1);
        logic       k;
        logic [7:0] d;
        bm.start();
        bm.wr_byte({DEV_TYPE, SEL, 1'b1}, k);
        check(8'(k), 8'h1);
        bm.rd_byte(1'b1, d);
        check(d, e0);
        bm.rd_byte(1'b0, d);
        check(d, e1);
        bm.stop();
        check(8'(busy), 8'h0);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 2 * WRC && busy !== 1'b0; i++) @(posedge clk);
        check(8'(busy), 8'h0);
    endtask

    task automatic t_refuse();
        logic k;
        bm.start();
        bm.wr_byte({4'h9, SEL, 1'b0}, k);
        check(8'(k), 8'h0);
        bm.stop();
        bm.start();
        bm.wr_byte({DEV_TYPE, SEL ^ 3'h1, 1'b1}, k);
        check(8'(k), 8'h0);
        bm.stop();
        $display("refusal test done");
    endtask

    task automatic t_byte_write();
        logic k;
        hdr(16'h8000);
        bm.wr_byte(8'h5a, k);
        check(8'(k), 8'h1);
        bm.stop();
        check(8'(busy), 8'h1);
        // poll while the write runs
        bm.start();
        bm.wr_byte({DEV_TYPE, SEL, 1'b0}, k);
        check(8'(k), 8'h0);
        bm.stop();
        wait_idle();
        check(mem[15'h0000], 8'h5a);
        hdr(16'h7fff);
        rd_chk(8'hff, 8'h5a);
        $display("byte write test done");
    endtask

    task automatic t_page();
        logic       k;
        logic [7:0] v [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
        hdr(16'h02be);
        for (int i = 0; i < 4; i++) begin
            bm.wr_byte(v[i], k);
            check(8'(k), 8'h1);
        end
        bm.stop();
        wait_idle();
        check(mem[15'h02be], 8'h11);
        check(mem[15'h02bf], 8'h22);
        check(mem[15'h0280], 8'h33);
        check(mem[15'h0281], 8'h44);
        check(mem[15'h02c0], 8'hff);
        rd_chk(8'hff, 8'hff);
        $display("page write test done");
    endtask

    task automatic t_wp();
        logic k;
        wp <= 1'b1;
        hdr(16'h0040);
        bm.wr_byte(8'ha5, k);
        check(8'(k), 8'h0);
        bm.stop();
        check(8'(busy), 8'h0);
        wp <= 1'b0;
        repeat (80) @(posedge clk);
        check(mem[15'h0040], 8'hff);
        $display("protect test done");
    endtask

    task automatic t_counter();
        hdr(16'h0000);
        bm.stop();
        check(8'(busy), 8'h0);
        rd_chk(8'h5a, 8'hff);
        $display("counter test done");
    endtask

    // reset, scenarios in order, then the verdict
    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        sel = SEL;
        fails = 0;
        samples_checked = 0;
        for (int i = 0; i < 32768; i++) mem[i] = ERASED;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_refuse();
        t_byte_write();
        t_page();
        t_wp();
        t_counter();
        end_of_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        $display("ERROR t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule
